// ==== rtl/tcu_defines.svh ====
`ifndef TCU_DEFINES_SVH
`define TCU_DEFINES_SVH
// Register indices (8-bit registers, one per address)
`define TCU_ADDR_W       4
`define TCU_REG_CTRL     4'h0
`define TCU_REG_COUNT    4'h1
`define TCU_REG_CMP      4'h2
`define TCU_REG_ASYNC    4'h3
`define TCU_REG_FLAGS    4'h4
`define TCU_REG_MASK     4'h5
// Control register fields
`define TCU_CTRL_FORCE   7
`define TCU_CTRL_WGM0    6
`define TCU_CTRL_COM_HI  5
`define TCU_CTRL_COM_LO  4
`define TCU_CTRL_WGM1    3
`define TCU_CTRL_CS_HI   2
`define TCU_CTRL_CS_LO   0
// Flag, mask and async select bit positions
`define TCU_BIT_CMP      7
`define TCU_BIT_OVF      6
`define TCU_BIT_ASYNC    3
// Counter values
`define TCU_BOTTOM       8'h00
`define TCU_MAX          8'hff
`define TCU_RESET_VAL    8'h00
`endif

// ==== rtl/tcu_pkg.sv ====
package tcu_pkg;
    typedef enum logic [1:0] {
        TCU_NORMAL, TCU_PWM_PC, TCU_CTC, TCU_PWM_FAST
    } tcu_wave_t;
endpackage : tcu_pkg

// ==== rtl/tcu_prescaler.sv ====
`timescale 1ns/10ps
`include "tcu_defines.svh"
// Tick source: stop, io clock divided, or crystal input edges
module tcu_prescaler (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [2:0] clockSelect,
    input  wire logic       asyncSel,
    input  wire logic       crystalIn,
    output logic            tick
);
    typedef struct packed {
        logic [9:0] div;
        logic       xtalSync1;
        logic       xtalSync2;
        logic       xtalLast;
        logic       tick;
    } tcu_pre_state_t;
    tcu_pre_state_t s_q, s_d;
    logic srcEdge;
    logic tapHit;

    // Tap selection: /1 /8 /32 /64 /128 /256 /1024
    always_comb begin
        s_d = s_q;
        s_d.xtalSync1 = crystalIn;
        s_d.xtalSync2 = s_q.xtalSync1;
        s_d.xtalLast = s_q.xtalSync2;
        srcEdge = asyncSel ? (s_q.xtalSync2 & ~s_q.xtalLast) : 1'b1;
        if (srcEdge) begin
            s_d.div = s_q.div + 10'h001;
        end
        unique case (clockSelect)
            3'h1: tapHit = 1'b1;
            3'h2: tapHit = (s_q.div[2:0] == 3'h7);
            3'h3: tapHit = (s_q.div[4:0] == 5'h1f);
            3'h4: tapHit = (s_q.div[5:0] == 6'h3f);
            3'h5: tapHit = (s_q.div[6:0] == 7'h7f);
            3'h6: tapHit = (s_q.div[7:0] == 8'hff);
            3'h7: tapHit = (s_q.div == 10'h3ff);
            default: tapHit = 1'b0;
        endcase
        s_d.tick = srcEdge & tapHit & (clockSelect != 3'h0);
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign tick = s_q.tick;
endmodule : tcu_prescaler

// ==== rtl/tcu_timer.sv ====
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "tcu_defines.svh"
module tcu_timer (
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire logic [`TCU_ADDR_W-1:0]  addr,
    input  wire logic [7:0]              wdata,
    input  wire logic                    wrStb,
    input  wire logic                    rdStb,
    input  wire logic                    cmpIrqAck,
    input  wire logic                    ovfIrqAck,
    input  wire logic                    crystalIn,
    input  wire logic                    pinDirection,
    input  wire logic                    portData,
    output logic [7:0]                   rdata,
    output logic                         cmpIrq,
    output logic                         ovfIrq,
    output logic                         compareOutput,
    output logic                         pinOut,
    output logic                         pinOutEn_n,
    output logic                         crystalOut
);
    typedef struct packed {
        tcu_pkg::tcu_wave_t waveMode;
        logic [1:0] outMode;
        logic [2:0] clockSel;
        logic       asyncSel;
        logic [7:0] count;
        logic [7:0] cmpActive;
        logic [7:0] cmpBuffer;
        logic       downCount;
        logic       blockMatch;
        logic       matchPend;
        logic       cmpFlag;
        logic       ovfFlag;
        logic       cmpIrqEn;
        logic       ovfIrqEn;
        logic       ocState;
        logic [7:0] rdata;
        logic       cmpIrq;
        logic       ovfIrq;
        logic       pinOut;
        logic       pinOutEn_n;
        logic       xtalOut;
    } tcu_state_t;
    tcu_state_t s_q, s_d;
    logic tick;
    logic isPwm;
    logic match;
    logic [7:0] topVal;
    logic wrCtrl, wrCount, wrCmp, wrFlags, wrMask;
    logic forceHit, ovfSet;

    // Apply output mode action to compare output state
    function automatic logic ocAction(input logic [1:0] mode,
                                      input logic       cur,
                                      input logic       setLvl);
        unique case (mode)
            2'h0: ocAction = cur;
            2'h1: ocAction = ~cur;
            2'h2: ocAction = ~setLvl;
            2'h3: ocAction = setLvl;
        endcase
    endfunction : ocAction

    tcu_prescaler u_pre (
        .clk         (clk),
        .rstn        (rstn),
        .clockSelect (s_q.clockSel),
        .asyncSel    (s_q.asyncSel),
        .crystalIn   (crystalIn),
        .tick        (tick)
    );

    // Decode and compare
    always_comb begin
        isPwm  = (s_q.waveMode == tcu_pkg::TCU_PWM_PC) ||
                 (s_q.waveMode == tcu_pkg::TCU_PWM_FAST);
        match  = (s_q.count == s_q.cmpActive);
        topVal = (s_q.waveMode == tcu_pkg::TCU_CTC) ? s_q.cmpActive
                                                   : `TCU_MAX;
        wrCtrl  = wrStb && (addr == `TCU_REG_CTRL);
        wrCount = wrStb && (addr == `TCU_REG_COUNT);
        wrCmp   = wrStb && (addr == `TCU_REG_CMP);
        wrFlags = wrStb && (addr == `TCU_REG_FLAGS);
        wrMask  = wrStb && (addr == `TCU_REG_MASK);
        // Force acts on the mode and output bits being written
        forceHit = wrCtrl && wdata[`TCU_CTRL_FORCE] &&
                   !wdata[`TCU_CTRL_WGM0];
        // Overflow at wrap to zero when TOP is MAX, or at BOTTOM turnaround
        ovfSet = tick &&
                 ((s_q.waveMode != tcu_pkg::TCU_PWM_PC &&
                   s_q.count == topVal && topVal == `TCU_MAX) ||
                  (s_q.waveMode == tcu_pkg::TCU_PWM_PC &&
                   s_q.count == `TCU_BOTTOM));
    end

    // Next state
    always_comb begin
        s_d = s_q;
        // Counter sequence per tick
        if (tick) begin
            s_d.matchPend = match && !s_q.blockMatch;
            s_d.blockMatch = 1'b0;
            unique case (s_q.waveMode)
                tcu_pkg::TCU_NORMAL, tcu_pkg::TCU_PWM_FAST: begin
                    s_d.count = s_q.count + 8'h01;
                end
                tcu_pkg::TCU_CTC: begin
                    s_d.count = (match) ? `TCU_BOTTOM
                                        : s_q.count + 8'h01;
                end
                tcu_pkg::TCU_PWM_PC: begin
                    if (s_q.downCount) begin
                        s_d.count = s_q.count - 8'h01;
                        if (s_q.count == 8'h01) begin
                            s_d.downCount = 1'b0;
                        end
                    end else begin
                        s_d.count = s_q.count + 8'h01;
                        if (s_q.count == 8'hfe) begin
                            s_d.downCount = 1'b1;
                        end
                    end
                end
            endcase
            // Compare output waveform
            if (match && !s_q.blockMatch) begin
                if (isPwm) begin
                    s_d.ocState = ocAction(s_q.outMode, s_q.ocState,
                                           s_q.waveMode == tcu_pkg::TCU_PWM_PC
                                           ? ~s_q.downCount : 1'b1);
                end else begin
                    s_d.ocState = ocAction(s_q.outMode, s_q.ocState, 1'b1);
                end
            end
            if (s_q.waveMode == tcu_pkg::TCU_PWM_FAST &&
                s_q.count == `TCU_MAX && s_q.outMode[1]) begin
                s_d.ocState = ~s_q.outMode[0];
            end
            // Buffered compare loads at TOP in both PWM modes
            if ((s_q.waveMode == tcu_pkg::TCU_PWM_FAST &&
                 s_q.count == `TCU_MAX) ||
                (s_q.waveMode == tcu_pkg::TCU_PWM_PC &&
                 s_q.count == 8'hfe && !s_q.downCount)) begin
                s_d.cmpActive = s_q.cmpBuffer;
            end
        end
        // Flag set one tick after the match
        if (tick && s_q.matchPend) begin
            s_d.cmpFlag = 1'b1;
        end
        // Flag clears: service or write one, set wins
        if ((cmpIrqAck || (wrFlags && wdata[`TCU_BIT_CMP])) &&
            !(tick && s_q.matchPend)) begin
            s_d.cmpFlag = 1'b0;
        end
        if (ovfSet) begin
            s_d.ovfFlag = 1'b1;
        end else if (ovfIrqAck || (wrFlags && wdata[`TCU_BIT_OVF])) begin
            s_d.ovfFlag = 1'b0;
        end
        // Software counter write wins and blocks next match
        if (wrCount) begin
            s_d.count = wdata;
            s_d.blockMatch = 1'b1;
            s_d.matchPend = 1'b0;
        end
        // Compare value writes
        if (wrCmp) begin
            s_d.cmpBuffer = wdata;
            if (!isPwm) begin
                s_d.cmpActive = wdata;
            end
        end
        // Control write: mode bits act at once, state kept
        if (wrCtrl) begin
            s_d.waveMode = tcu_pkg::tcu_wave_t'({wdata[`TCU_CTRL_WGM1],
                                                wdata[`TCU_CTRL_WGM0]});
            s_d.outMode  = wdata[`TCU_CTRL_COM_HI:`TCU_CTRL_COM_LO];
            s_d.clockSel = wdata[`TCU_CTRL_CS_HI:`TCU_CTRL_CS_LO];
        end
        if (forceHit) begin
            s_d.ocState = ocAction(wdata[`TCU_CTRL_COM_HI:`TCU_CTRL_COM_LO],
                                   s_q.ocState, 1'b1);
        end
        if (wrStb && addr == `TCU_REG_ASYNC) begin
            s_d.asyncSel = wdata[`TCU_BIT_ASYNC];
        end
        if (wrMask) begin
            s_d.cmpIrqEn = wdata[`TCU_BIT_CMP];
            s_d.ovfIrqEn = wdata[`TCU_BIT_OVF];
        end
        // Read data, one cycle after the strobe
        s_d.rdata = 8'h00;
        if (rdStb) begin
            unique case (addr)
                `TCU_REG_CTRL: s_d.rdata = {1'b0, s_q.waveMode[0],
                    s_q.outMode, s_q.waveMode[1], s_q.clockSel};
                `TCU_REG_COUNT: s_d.rdata = s_q.count;
                `TCU_REG_CMP: s_d.rdata = isPwm ? s_q.cmpBuffer
                                                : s_q.cmpActive;
                `TCU_REG_ASYNC: s_d.rdata = {4'h0, s_q.asyncSel, 3'h0};
                `TCU_REG_FLAGS: s_d.rdata = {s_q.cmpFlag, s_q.ovfFlag,
                                             6'h00};
                `TCU_REG_MASK: s_d.rdata = {s_q.cmpIrqEn, s_q.ovfIrqEn,
                                            6'h00};
                default: s_d.rdata = 8'h00;
            endcase
        end
        // Interrupt requests and pin override
        s_d.cmpIrq = s_d.cmpFlag && s_d.cmpIrqEn;
        s_d.ovfIrq = s_d.ovfFlag && s_d.ovfIrqEn;
        s_d.pinOut = (s_d.outMode != 2'h0) ? s_d.ocState
                                           : portData;
        s_d.pinOutEn_n = ~pinDirection;
        s_d.xtalOut = ~crystalIn;
    end

    // State register, all zero after reset
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata         = s_q.rdata;
    assign cmpIrq        = s_q.cmpIrq;
    assign ovfIrq        = s_q.ovfIrq;
    assign compareOutput = s_q.ocState;
    assign pinOut        = s_q.pinOut;
    assign pinOutEn_n    = s_q.pinOutEn_n;
    assign crystalOut    = s_q.xtalOut;

    // Assertions
    property p_flag_after_match;
        @(posedge clk) disable iff (!rstn)
        (tick && s_q.matchPend) |=> s_q.cmpFlag;
    endproperty
    a_p_flag_after_match: assert property (p_flag_after_match)
        else $error("flag not set after match");

    property p_match_pend;
        @(posedge clk) disable iff (!rstn)
        (tick && match && !s_q.blockMatch && !wrCount) |=> s_q.matchPend;
    endproperty
    a_p_match_pend: assert property (p_match_pend)
        else $error("match not registered");

    property p_irq;
        @(posedge clk) disable iff (!rstn)
        (s_q.cmpFlag && s_q.cmpIrqEn) |-> cmpIrq;
    endproperty
    a_p_irq: assert property (p_irq)
        else $error("irq missing");

    property p_stopped;
        @(posedge clk) disable iff (!rstn)
        (s_q.clockSel == 3'h0 && !wrCount) [*2] |=> $stable(s_q.count);
    endproperty
    a_p_stopped: assert property (p_stopped)
        else $error("counter moved while stopped");

    property p_write_wins;
        @(posedge clk) disable iff (!rstn)
        wrCount |=> (s_q.count == $past(wdata));
    endproperty
    a_p_write_wins: assert property (p_write_wins)
        else $error("counter write lost");

    property p_block;
        @(posedge clk) disable iff (!rstn)
        (wrCount ##1 (tick && !wrCount)) |=> !s_q.matchPend;
    endproperty
    a_p_block: assert property (p_block)
        else $error("match not blocked");

    property p_ack_clear;
        @(posedge clk) disable iff (!rstn)
        (cmpIrqAck && !(tick && s_q.matchPend)) |=> !s_q.cmpFlag;
    endproperty
    a_p_ack_clear: assert property (p_ack_clear)
        else $error("flag not cleared");

    property p_ctc_clear;
        @(posedge clk) disable iff (!rstn)
        (tick && s_q.waveMode == tcu_pkg::TCU_CTC && match && !wrCount)
            |=> (s_q.count == 8'h00);
    endproperty
    a_p_ctc_clear: assert property (p_ctc_clear)
        else $error("ctc did not clear");

    property p_direct_cmp;
        @(posedge clk) disable iff (!rstn)
        (wrCmp && !isPwm) |=> (s_q.cmpActive == $past(wdata));
    endproperty
    a_p_direct_cmp: assert property (p_direct_cmp)
        else $error("direct compare write lost");

    property p_force_noflag;
        @(posedge clk) disable iff (!rstn)
        (forceHit && !s_q.cmpFlag && !(tick && s_q.matchPend))
            |=> !s_q.cmpFlag;
    endproperty
    a_p_force_noflag: assert property (p_force_noflag)
        else $error("force set flag");

    c_match: cover property (@(posedge clk) s_q.cmpFlag);
    c_ovf: cover property (@(posedge clk) s_q.ovfFlag);
    c_force: cover property (@(posedge clk) forceHit);
endmodule : tcu_timer

// ==== bench/tcu_testbench.sv ====
`timescale 1ns/10ps
`include "tcu_defines.svh"
module testbench;
    logic                   clk;
    logic                   rstn;
    logic [`TCU_ADDR_W-1:0] addr;
    logic [7:0]             wdata;
    logic                   wrStb;
    logic                   rdStb;
    logic                   cmpIrqAck;
    logic                   ovfIrqAck;
    logic                   crystalIn;
    logic                   pinDirection;
    logic                   portData;
    logic [7:0]             rdata;
    logic                   cmpIrq;
    logic                   ovfIrq;
    logic                   compareOutput;
    logic                   pinOut;
    logic                   pinOutEn_n;
    logic                   crystalOut;
    int                     numErrors;
    int                     nCompared;
    logic [7:0]             rv;

    tcu_timer tcu_timer_inst (
        .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wrStb(wrStb), .rdStb(rdStb), .cmpIrqAck(cmpIrqAck),
        .ovfIrqAck(ovfIrqAck), .crystalIn(crystalIn),
        .pinDirection(pinDirection), .portData(portData),
        .rdata(rdata), .cmpIrq(cmpIrq), .ovfIrq(ovfIrq),
        .compareOutput(compareOutput), .pinOut(pinOut),
        .pinOutEn_n(pinOutEn_n), .crystalOut(crystalOut)
    );

    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Ends the run with the verdict
    task automatic summarize();
        if (numErrors == 0 && nCompared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    // Compares one value and counts the outcome
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        nCompared++;
        if (got !== exp) begin
            numErrors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    // One-cycle register write
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wrStb <= 1'b1;
        @(posedge clk);
        wrStb <= 1'b0;
    endtask : wr

    // One-cycle register read, data taken in the following cycle
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        #1 d = rdata;
    endtask : rd

    // One-cycle service pulse on an acknowledge input
    task automatic ack(input bit cmp);
        @(posedge clk);
        if (cmp) cmpIrqAck <= 1'b1; else ovfIrqAck <= 1'b1;
        @(posedge clk);
        cmpIrqAck <= 1'b0;
        ovfIrqAck <= 1'b0;
    endtask : ack

    // All registers zero after reset, unmapped index reads zero
    task automatic t_reset();
        for (int i = 0; i < 7; i++) begin
            rd(i[3:0], rv);
            chk("regAfterReset", 8'h00, rv);
        end
        rv = {5'h00, cmpIrq, ovfIrq, compareOutput};
        chk("outAfterReset", 8'h00, rv);
        chk("pinOutEnAfterReset", 8'h01, {7'h00, pinOutEn_n});
    endtask : t_reset

    // Stopped counter keeps a software written value
    task automatic t_stopped();
        wr(`TCU_REG_COUNT, 8'h5a);
        repeat (30) @(posedge clk);
        rd(`TCU_REG_COUNT, rv);
        chk("stoppedCount", 8'h5a, rv);
    endtask : t_stopped

    // Match raises flag and interrupt; service and write-one clear it
    task automatic t_match();
        int n;
        wr(`TCU_REG_CMP, 8'h20);
        wr(`TCU_REG_COUNT, 8'h00);
        wr(`TCU_REG_MASK, 8'h80);
        for (int pass = 0; pass < 2; pass++) begin
            wr(`TCU_REG_CTRL, 8'h01);
            n = 0;
            while (cmpIrq !== 1'b1 && n < 400) begin
                @(posedge clk);
                n++;
            end
            wr(`TCU_REG_CTRL, 8'h00);
            chk("cmpIrqRaised", 8'h01, {7'h00, cmpIrq});
            rd(`TCU_REG_FLAGS, rv);
            chk("flagsAtMatch", 8'h80, rv);
            if (pass == 0) ack(1'b1);
            else wr(`TCU_REG_FLAGS, 8'h80);
            rd(`TCU_REG_FLAGS, rv);
            chk("flagsCleared", 8'h00, rv);
            chk("cmpIrqCleared", 8'h00, {7'h00, cmpIrq});
            wr(`TCU_REG_COUNT, 8'h1c);
        end
    endtask : t_match

    // Normal mode wraps through 0xff and sets the overflow flag
    task automatic t_overflow();
        wr(`TCU_REG_MASK, 8'h00);
        wr(`TCU_REG_COUNT, 8'hf0);
        wr(`TCU_REG_CTRL, 8'h01);
        repeat (40) @(posedge clk);
        wr(`TCU_REG_CTRL, 8'h00);
        rd(`TCU_REG_FLAGS, rv);
        chk("flagsOverflow", 8'h40, rv);
        chk("ovfIrqMasked", 8'h00, {7'h00, ovfIrq});
        wr(`TCU_REG_MASK, 8'h40);
        repeat (2) @(posedge clk);
        chk("ovfIrqEnabled", 8'h01, {7'h00, ovfIrq});
        ack(1'b0);
        rd(`TCU_REG_FLAGS, rv);
        chk("ovfServiced", 8'h00, rv);
        wr(`TCU_REG_MASK, 8'h00);
    endtask : t_overflow

    // Running counter written equal to compare: write wins, match blocked
    task automatic t_block();
        wr(`TCU_REG_CMP, 8'h30);
        wr(`TCU_REG_CTRL, 8'h01);
        wr(`TCU_REG_COUNT, 8'h30);
        repeat (20) @(posedge clk);
        wr(`TCU_REG_CTRL, 8'h00);
        rd(`TCU_REG_FLAGS, rv);
        chk("flagsBlocked", 8'h00, rv);
    endtask : t_block

    // Clear-on-match keeps the counter at or below compare
    task automatic t_ctc();
        wr(`TCU_REG_CMP, 8'h05);
        wr(`TCU_REG_COUNT, 8'h00);
        wr(`TCU_REG_CTRL, 8'h09);
        repeat (60) @(posedge clk);
        wr(`TCU_REG_CTRL, 8'h00);
        rd(`TCU_REG_COUNT, rv);
        chk("ctcBounded", 8'h01, {7'h00, rv <= 8'h05});
        rd(`TCU_REG_FLAGS, rv);
        chk("ctcFlag", 8'h80, rv & 8'h80);
        wr(`TCU_REG_FLAGS, 8'hc0);
    endtask : t_ctc

    // Force strobe toggles output only in non-PWM modes
    task automatic t_force();
        portData     <= 1'b0;
        wr(`TCU_REG_COUNT, 8'h11);
        wr(`TCU_REG_CTRL, 8'h90);
        pinDirection <= 1'b1;
        repeat (2) @(posedge clk);
        chk("forcedOut", 8'h01, {7'h00, compareOutput});
        rd(`TCU_REG_FLAGS, rv);
        chk("forceNoFlag", 8'h00, rv);
        rd(`TCU_REG_COUNT, rv);
        chk("forceNoClear", 8'h11, rv);
        wr(`TCU_REG_CTRL, 8'hd0);
        repeat (2) @(posedge clk);
        chk("pwmForceIgnored", 8'h01, {7'h00, compareOutput});
        chk("pinOverride", 8'h01, {7'h00, pinOut});
        chk("pinEnabled", 8'h00, {7'h00, pinOutEn_n});
        wr(`TCU_REG_CTRL, 8'h00);
        repeat (2) @(posedge clk);
        chk("pinPortData", 8'h00, {7'h00, pinOut});
        chk("outKept", 8'h01, {7'h00, compareOutput});
    endtask : t_force

    // Crystal edges drive the tick when async select is set
    task automatic t_async();
        wr(`TCU_REG_COUNT, 8'h00);
        wr(`TCU_REG_ASYNC, 8'h08);
        rd(`TCU_REG_ASYNC, rv);
        chk("asyncReg", 8'h08, rv);
        wr(`TCU_REG_CTRL, 8'h01);
        repeat (20) @(posedge clk);
        rd(`TCU_REG_COUNT, rv);
        chk("noCrystalNoTick", 8'h00, rv);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) crystalIn <= 1'b1;
            repeat (6) @(posedge clk);
            chk("crystalOut", 8'h00, {7'h00, crystalOut});
            crystalIn <= 1'b0;
            repeat (6) @(posedge clk);
            chk("crystalOutHigh", 8'h01, {7'h00, crystalOut});
        end
        wr(`TCU_REG_CTRL, 8'h00);
        rd(`TCU_REG_COUNT, rv);
        chk("crystalTicks", 8'h04, rv);
    endtask : t_async

    // Fast PWM: compare writes wait in the buffer until TOP
    task automatic t_pwm();
        wr(`TCU_REG_ASYNC, 8'h00);
        wr(`TCU_REG_CTRL, 8'h68);
        wr(`TCU_REG_CMP, 8'h40);
        rd(`TCU_REG_CMP, rv);
        chk("pwmCmpBuffer", 8'h40, rv);
        for (int pass = 0; pass < 2; pass++) begin
            wr(`TCU_REG_COUNT, pass == 0 ? 8'h00 : 8'hfc);
            wr(`TCU_REG_CTRL, 8'h69);
            repeat (10) @(posedge clk);
            wr(`TCU_REG_CTRL, 8'h68);
            rd(`TCU_REG_FLAGS, rv);
            chk("pwmFlags", pass == 0 ? 8'h80 : 8'h40, rv);
            rv = {7'h00, compareOutput};
            chk("pwmOutput", pass == 0 ? 8'h00 : 8'h01, rv);
            wr(`TCU_REG_FLAGS, 8'hc0);
        end
        wr(`TCU_REG_CTRL, 8'h00);
    endtask : t_pwm

    // Hang guard
    initial begin
        #200000;
        numErrors++;
        summarize();
    end

    // Reset then scenarios
    initial begin
        numErrors = 0;
        nCompared = 0;
        rstn = 1'b0;
        {addr, wdata, wrStb, rdStb, cmpIrqAck, ovfIrqAck} = '0;
        {crystalIn, pinDirection, portData} = '0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_stopped();
        t_match();
        t_overflow();
        t_block();
        t_ctc();
        t_force();
        t_async();
        t_pwm();
        summarize();
    end
endmodule : testbench
